// *** nbc_pkg.sv ***
// Purpose: shared constants and types for the nibble instruction executor
// Assumes: 16-bit instruction words, 4-bit data memory of 256 nibbles
// Notes:   opcodes are the 6-bit leading field of the word
package nbc_pkg;
  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 10;
  localparam int ROW_MSB = 9;
  localparam int ROW_LSB = 8;
  localparam int COL_MSB = 7;
  localparam int COL_LSB = 4;
  localparam int OPD_MSB = 3;
  localparam int OPD_LSB = 0;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [5:0] op_mem_or_imm                   = 6'h06;
  localparam logic [5:0] op_mem_and_imm                  = 6'h07;
  localparam logic [5:0] op_mem_minus_imm                = 6'h08;
  localparam logic [5:0] op_mem_minus_imm_skip_brw       = 6'h09;
  localparam logic [5:0] op_mem_minus_imm_skip_nobrw     = 6'h0A;
  localparam logic [5:0] op_mem_minus_imm_brw            = 6'h0B;
  localparam logic [5:0] op_mem_minus_imm_brw_skip_brw   = 6'h0C;
  localparam logic [5:0] op_mem_minus_imm_brw_skip_nobrw = 6'h0D;
  localparam logic [5:0] op_mem_xor_imm                  = 6'h0E;
  localparam logic [5:0] op_imm_load_mem                 = 6'h0F;
  localparam logic [5:0] op_reg_or_mem                   = 6'h16;
  localparam logic [5:0] op_reg_and_mem                  = 6'h17;
  localparam logic [5:0] op_reg_minus_mem                = 6'h18;
  localparam logic [5:0] op_reg_minus_mem_skip_brw       = 6'h19;
  localparam logic [5:0] op_reg_minus_mem_skip_nobrw     = 6'h1A;
  localparam logic [5:0] op_reg_minus_mem_brw            = 6'h1B;
  localparam logic [5:0] op_reg_minus_mem_brw_skip_brw   = 6'h1C;
  localparam logic [5:0] op_reg_minus_mem_brw_skip_nobrw = 6'h1D;
  localparam logic [5:0] op_reg_xor_mem                  = 6'h1E;
  localparam logic [5:0] op_row_move                     = 6'h1F;
  localparam logic [5:0] op_skip_reg_eq_mem              = 6'h22;
  localparam logic [5:0] op_skip_reg_ne_mem              = 6'h23;
  localparam logic [5:0] op_copy_mem_to_reg              = 6'h24;
  localparam logic [5:0] op_copy_reg_to_mem              = 6'h25;
  localparam logic [5:0] op_indirect_dest_move           = 6'h26;
  localparam logic [5:0] op_indirect_src_move            = 6'h27;
  localparam logic [5:0] op_skip_mem_below_imm           = 6'h30;
  localparam logic [5:0] op_skip_mem_atleast_imm         = 6'h31;
  localparam logic [5:0] op_skip_mem_eq_imm              = 6'h32;
  localparam logic [5:0] op_skip_mem_ne_imm              = 6'h33;
  localparam logic [5:0] op_port_read_group1             = 6'h38;
  localparam logic [5:0] op_port_read_group2             = 6'h39;
  localparam logic [5:0] op_port_read_group3             = 6'h3A;
  localparam logic [5:0] op_port_write_group1           = 6'h3B;
  localparam logic [5:0] op_port_write_group2           = 6'h3C;
  localparam logic [5:0] op_port_write_group3           = 6'h3D;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [11:0] PC_RESET      = 12'h000;
  localparam logic        BORROW_RESET  = 1'b0;
  localparam logic [3:0]  GREG_RESET    = 4'h0;
  localparam int          MACHINE_CYCLES_LONG = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] opc;
    logic [1:0] row_field;
    logic [3:0] column_field;
    logic [3:0] operand;
  } nbc_insn_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] group;
    logic [3:0] port_code_field;
    logic [3:0] data;
  } nbc_port_t;

  typedef enum logic [1:0] {
    NBC_EXEC  = 2'b01,
    NBC_FETCH2 = 2'b10
  } nbc_state_t;
endpackage

// *** nbc_exec.sv ***
// Purpose: executes subtract, compare, move, port and logic instructions
// Assumes: one instruction per enabled machine cycle (two for 100111), on-chip nibble RAM
// Notes:   other opcodes are accepted and only advance the program counter
//
// Functional notes
// - 001000: memory minus immediate written back to memory.
// - 001001/001010: same, skip on borrow / on no borrow.
// - 001011-001101: memory minus immediate minus borrow; no skip, skip borrow, no borrow.
// - 011000: register minus memory written to register.
// - 011001/011010: same, skip on borrow / on no borrow.
// - 011011-011101: register minus memory minus borrow; three skip variants.
// - 110000/110001: skip if memory below / at least immediate, unsigned.
// - 110010/110011: skip if memory equals / differs from immediate.
// - 100010/100011: skip if register equals / differs from memory.
// - 100100 copies memory to register; 100101 register to memory.
// - 011111: move second column to first column within one row.
// - 001111: immediate written straight into memory.
// - indirect address is G high, register low; 100110 write, 100111 read.
// - port group plus code selects port; reads into memory, writes from memory.
// - 010110 register OR memory; 010111 register AND memory.
// - 000110 memory OR immediate; 000111 memory AND immediate.
// - 001110 memory XOR immediate; 011110 register XOR memory.
// - word splits into 6-bit opcode, 2-bit row, 4-bit column, 4-bit operand.
// - register number indexes memory nibbles 00H to 0FH.
// - indirect source move takes two machine cycles.
`timescale 1ns/1ps
`default_nettype none
module nbc_exec
  import nbc_pkg::*;
#(
  parameter int PC_W  = 12,
  parameter int MEM_D = 256
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            clk_en,
  input  wire logic [15:0]     insn_word,
  input  wire logic [3:0]      port_rd_data,
  output logic      [PC_W-1:0] pc_q,
  output logic                 borrow_q,
  output logic      [3:0]      greg_q,
  output nbc_port_t            port_rd_q,
  output nbc_port_t            port_wr_q,
  output logic                 busy
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  nbc_insn_t  insn;
  nbc_state_t state_q;
  logic [3:0] mem [MEM_D];
  logic [7:0] m_addr;
  logic [7:0] r_addr;
  logic [7:0] m2_addr;
  logic [7:0] ind_addr;
  logic [3:0] m_val;
  logic [3:0] r_val;
  logic [3:0] ind_val;
  logic [4:0] diff;
  logic       brw_in;
  logic       uses_brw;
  logic       is_sub_imm;
  logic       is_sub_reg;
  logic       skip;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [3:0] wr_data;
  logic [PC_W-1:0] pc_d;

  function automatic logic [7:0] row_col(input logic [1:0] row, input logic [3:0] col);
    row_col = {2'b00, row, col};
  endfunction

  // ----------------------------------------------------------------
  // opcode classes
  // ----------------------------------------------------------------
  // subtract and port groups are contiguous, so one range test serves each of those four classes
  function automatic logic in_range(
    input logic [5:0] opc,
    input logic [5:0] lo,
    input logic [5:0] hi
  );
    in_range = opc >= lo && opc <= hi;
  endfunction

  assign insn     = nbc_insn_t'(insn_word);
  assign m_addr   = row_col(insn.row_field, insn.column_field);
  assign m2_addr  = row_col(insn.row_field, insn.operand);
  assign r_addr   = {4'h0, insn.operand};
  assign ind_addr = {greg_q, r_val};
  assign m_val    = mem[m_addr];
  assign r_val    = mem[r_addr];
  assign ind_val  = mem[ind_addr];

  assign is_sub_imm = in_range(insn.opc, op_mem_minus_imm, op_mem_minus_imm_brw_skip_nobrw);
  assign is_sub_reg = in_range(insn.opc, op_reg_minus_mem, op_reg_minus_mem_brw_skip_nobrw);
  // borrow-in is only meaningful inside the two subtract groups
  assign uses_brw   = insn.opc[2:0] >= 3'h3 && insn.opc[2:0] <= 3'h5;
  assign brw_in     = uses_brw & borrow_q;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // wrap modulo 16, bit 4 is borrow
  always_comb begin
    if (is_sub_reg) begin
      diff = {1'b0, r_val} - {1'b0, m_val} - {4'h0, brw_in};
    end else begin
      diff = {1'b0, m_val} - {1'b0, insn.operand} - {4'h0, brw_in};
    end
  end

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  always_comb begin
    skip    = 1'b0;
    wr_en   = 1'b0;
    wr_addr = m_addr;
    wr_data = diff[3:0];
    case (insn.opc)
      op_mem_minus_imm, op_mem_minus_imm_brw: begin
        wr_en = 1'b1;
      end
      op_mem_minus_imm_skip_brw, op_mem_minus_imm_brw_skip_brw: begin
        wr_en = 1'b1;
        skip  = diff[4];
      end
      op_mem_minus_imm_skip_nobrw, op_mem_minus_imm_brw_skip_nobrw: begin
        wr_en = 1'b1;
        skip  = ~diff[4];
      end
      op_reg_minus_mem, op_reg_minus_mem_brw: begin
        wr_en   = 1'b1;
        wr_addr = r_addr;
      end
      op_reg_minus_mem_skip_brw, op_reg_minus_mem_brw_skip_brw: begin
        wr_en   = 1'b1;
        wr_addr = r_addr;
        skip    = diff[4];
      end
      op_reg_minus_mem_skip_nobrw, op_reg_minus_mem_brw_skip_nobrw: begin
        wr_en   = 1'b1;
        wr_addr = r_addr;
        skip    = ~diff[4];
      end
      op_skip_mem_below_imm: begin
        skip = m_val < insn.operand;
      end
      op_skip_mem_atleast_imm: begin
        skip = m_val >= insn.operand;
      end
      op_skip_mem_eq_imm: begin
        skip = m_val == insn.operand;
      end
      op_skip_mem_ne_imm: begin
        skip = m_val != insn.operand;
      end
      op_skip_reg_eq_mem: begin
        skip = r_val == m_val;
      end
      op_skip_reg_ne_mem: begin
        skip = r_val != m_val;
      end
      op_copy_mem_to_reg: begin
        wr_en   = 1'b1;
        wr_addr = r_addr;
        wr_data = m_val;
      end
      op_copy_reg_to_mem: begin
        wr_en   = 1'b1;
        wr_data = r_val;
      end
      op_row_move: begin
        wr_en   = 1'b1;
        wr_data = mem[m2_addr];
      end
      op_imm_load_mem: begin
        wr_en   = 1'b1;
        wr_data = insn.operand;
      end
      op_indirect_dest_move: begin
        wr_en   = 1'b1;
        wr_addr = ind_addr;
        wr_data = m_val;
      end
      // indirect source, written in second cycle
      op_indirect_src_move: begin
        wr_en   = state_q == NBC_FETCH2;
        wr_data = ind_val;
      end
      op_port_read_group1, op_port_read_group2, op_port_read_group3: begin
        wr_en   = 1'b1;
        wr_data = port_rd_data;
      end
      op_reg_or_mem: begin
        wr_en   = 1'b1;
        wr_addr = r_addr;
        wr_data = r_val | m_val;
      end
      op_reg_and_mem: begin
        wr_en   = 1'b1;
        wr_addr = r_addr;
        wr_data = r_val & m_val;
      end
      op_mem_or_imm: begin
        wr_en   = 1'b1;
        wr_data = m_val | insn.operand;
      end
      op_mem_and_imm: begin
        wr_en   = 1'b1;
        wr_data = m_val & insn.operand;
      end
      op_mem_xor_imm: begin
        wr_en   = 1'b1;
        wr_data = m_val ^ insn.operand;
      end
      op_reg_xor_mem: begin
        wr_en   = 1'b1;
        wr_addr = r_addr;
        wr_data = r_val ^ m_val;
      end
      default: begin
        wr_en = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // hold the word for a second cycle
  assign busy = state_q == NBC_EXEC && insn.opc == op_indirect_src_move;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= NBC_EXEC;
    end else if (clk_en) begin
      case (state_q)
        NBC_EXEC: begin
          state_q <= busy ? NBC_FETCH2 : NBC_EXEC;
        end
        NBC_FETCH2: begin
          state_q <= NBC_EXEC;
        end
        default: begin
          state_q <= NBC_EXEC;
        end
      endcase
    end
  end

  // skip steps over one word
  // pc held while busy so the same word stays on insn_word for cycle two
  always_comb begin
    if (busy) begin
      pc_d = pc_q;
    end else if (skip) begin
      pc_d = pc_q + PC_W'(2);
    end else begin
      pc_d = pc_q + PC_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pc_q <= PC_W'(PC_RESET);
    end else if (clk_en) begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      borrow_q <= BORROW_RESET;
    end else if (clk_en && (is_sub_imm || is_sub_reg)) begin
      borrow_q <= diff[4];
    end
  end

  // no reset on ram: contents are backed up by software, not cleared
  always_ff @(posedge clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // g register loaded as port code 0 of write group 1; port map lives elsewhere
  always_ff @(posedge clk) begin
    if (reset) begin
      greg_q <= GREG_RESET;
    end else if (clk_en && insn.opc == op_port_write_group1 && insn.operand == 4'h0) begin
      greg_q <= m_val;
    end
  end

  // port strobes with group and code
  // records refresh every enabled cycle; only valid qualifies them,
  // which saves a load enable on the wide fields
  always_ff @(posedge clk) begin
    if (reset) begin
      port_rd_q <= '0;
      port_wr_q <= '0;
    end else if (clk_en) begin
      port_rd_q.valid <= in_range(insn.opc, op_port_read_group1, op_port_read_group3);
      port_rd_q.group <= 2'(insn.opc - op_port_read_group1);
      port_rd_q.port_code_field <= insn.operand;
      port_rd_q.data  <= port_rd_data;
      port_wr_q.valid <= in_range(insn.opc, op_port_write_group1, op_port_write_group3);
      port_wr_q.group <= 2'(insn.opc - op_port_write_group1);
      port_wr_q.port_code_field <= insn.operand;
      port_wr_q.data  <= m_val;
    end
  end

endmodule
`default_nettype wire

// *** nbc_exec_properties.sv ***
// Purpose: port-level properties of the nibble executor
// Assumes: one clock, synchronous reset
// Notes:   memory contents are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module nbc_exec_properties
  import nbc_pkg::*;
#(
  parameter int PC_W = 12
) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            clk_en,
  input wire logic [15:0]     insn_word,
  input wire logic [3:0]      port_rd_data,
  input wire logic [PC_W-1:0] pc_q,
  input wire logic            borrow_q,
  input wire logic [3:0]      greg_q,
  input wire nbc_port_t       port_rd_q,
  input wire nbc_port_t       port_wr_q,
  input wire logic            busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [5:0] opc;
  logic       g_load;
  assign opc = insn_word[15:10];
  assign g_load = clk_en && opc == 6'h3B && insn_word[3:0] == 4'h0;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_step;
    clk_en && !busy |=> PC_W'(pc_q - $past(pc_q)) inside {1, 2};
  endproperty
  a_step: assert property (p_step) else $error("pc step not one or two");
  property p_plain;
    clk_en && !busy && opc inside {6'h08, 6'h0B, 6'h0F, 6'h1F, 6'h24, 6'h38}
      |=> pc_q == $past(pc_q) + 1'b1;
  endproperty
  a_plain: assert property (p_plain) else $error("non-skip op moved pc wrongly");
  property p_kept;
    clk_en && opc inside {[6'h22:6'h27], [6'h30:6'h33], [6'h38:6'h3D], 6'h06, 6'h07,
      6'h0E, 6'h0F, 6'h16, 6'h17, 6'h1E, 6'h1F} |=> borrow_q == $past(borrow_q);
  endproperty
  a_kept: assert property (p_kept) else $error("borrow changed by non-subtract");
  property p_busy_two;
    clk_en && busy |=> !busy && pc_q == $past(pc_q);
  endproperty
  a_busy_two: assert property (p_busy_two) else $error("long move not two cycles");
  property p_busy_src;
    busy |-> opc == 6'h27;
  endproperty
  a_busy_src: assert property (p_busy_src) else $error("busy on wrong opcode");
  property p_wr;
    clk_en && opc inside {[6'h3B:6'h3D]} |=> port_wr_q.valid
      && port_wr_q.group == 2'($past(opc[1:0]) + 2'h1)
      && port_wr_q.port_code_field == $past(insn_word[3:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("port write record wrong");
  property p_rd;
    clk_en && opc inside {[6'h38:6'h3A]} |=> port_rd_q.valid
      && port_rd_q.group == $past(opc[1:0]) && port_rd_q.data == $past(port_rd_data);
  endproperty
  a_rd: assert property (p_rd) else $error("port read record wrong");
  property p_no_wr;
    clk_en && !(opc inside {[6'h3B:6'h3D]}) |=> !port_wr_q.valid;
  endproperty
  a_no_wr: assert property (p_no_wr) else $error("spurious port write");
  property p_greg;
    g_load |=> greg_q == port_wr_q.data;
  endproperty
  a_greg: assert property (p_greg) else $error("g register not loaded");
  property p_greg_keep;
    !g_load |=> greg_q == $past(greg_q);
  endproperty
  a_greg_keep: assert property (p_greg_keep) else $error("g register changed");
endmodule
bind nbc_exec nbc_exec_properties #(.PC_W(PC_W)) u_props (
  .clk(clk), .reset(reset), .clk_en(clk_en), .insn_word(insn_word),
  .port_rd_data(port_rd_data), .pc_q(pc_q), .borrow_q(borrow_q), .greg_q(greg_q),
  .port_rd_q(port_rd_q), .port_wr_q(port_wr_q), .busy(busy)
);
`default_nettype wire

// *** nbc_exec_bench.sv ***
// Purpose: random and corner tests of the nibble executor
// Assumes: bench model mirrors memory, borrow, g and pc
// Notes:   memory is observed through port writes
`timescale 1ns/1ps
`default_nettype none
module nbc_exec_bench
  import nbc_pkg::*;
;
  localparam int LIMIT = 20000;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        clk_en = 1'b0;
  logic [15:0] insn_word = 16'h0000;
  logic [3:0]  port_rd_data = 4'h0;
  logic [11:0] pc_q;
  logic        borrow_q;
  logic [3:0]  greg_q;
  nbc_port_t   port_rd_q;
  nbc_port_t   port_wr_q;
  logic        busy;
  logic [3:0]  mem [256];
  logic [11:0] e_pc = 12'h000;
  logic        e_b = 1'b0;
  logic [3:0]  e_g = 4'h0;
  nbc_port_t   e_rd = '0;
  nbc_port_t   e_wr = '0;
  logic [31:0] seed = 32'h0000B7FE;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  nbc_exec DUT (
    .clk(clk), .reset(reset), .clk_en(clk_en), .insn_word(insn_word),
    .port_rd_data(port_rd_data), .pc_q(pc_q), .borrow_q(borrow_q), .greg_q(greg_q),
    .port_rd_q(port_rd_q), .port_wr_q(port_wr_q), .busy(busy)
  );

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    cmp_count++;
    if (exp !== got) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic void model(logic [15:0] w, logic [3:0] prd);
    logic [5:0] op;
    logic [7:0] ma, ra, ia;
    logic [3:0] m, r, i;
    logic [4:0] d;
    logic       sk;
    op = w[15:10];
    ma = {2'h0, w[9:4]};
    ra = {4'h0, w[3:0]};
    i = w[3:0];
    m = mem[ma];
    r = mem[ra];
    ia = {e_g, r};
    sk = 1'b0;
    e_rd.valid = 1'b0;
    e_wr.valid = 1'b0;
    // borrow-in for low codes above 2; only 3..5 reach the subtracts
    d = {1'b0, (op[4] ? r : m)} - {1'b0, (op[4] ? m : i)} - {4'h0, (op[2:0] > 3'h2 && e_b)};
    case (op)
      6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
      6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D: begin
        e_b = d[4];
        sk = op[2:0] inside {3'h1, 3'h4} ? d[4] : op[2:0] inside {3'h2, 3'h5} && !d[4];
        mem[op[4] ? ra : ma] = d[3:0];
      end
      6'h30: sk = m < i;
      6'h31: sk = m >= i;
      6'h32: sk = m == i;
      6'h33: sk = m != i;
      6'h22: sk = r == m;
      6'h23: sk = r != m;
      6'h24: mem[ra] = m;
      6'h25: mem[ma] = r;
      6'h1F: mem[ma] = mem[{2'h0, w[9:8], w[3:0]}];
      6'h0F: mem[ma] = i;
      6'h26: mem[ia] = m;
      6'h27: mem[ma] = mem[ia];
      6'h06: mem[ma] = m | i;
      6'h07: mem[ma] = m & i;
      6'h0E: mem[ma] = m ^ i;
      6'h16: mem[ra] = r | m;
      6'h17: mem[ra] = r & m;
      6'h1E: mem[ra] = r ^ m;
      6'h38, 6'h39, 6'h3A: begin
        mem[ma] = prd;
        e_rd = {1'b1, op[1:0], i, prd};
      end
      6'h3B, 6'h3C, 6'h3D: begin
        e_wr = {1'b1, op[1:0] + 2'h1, i, m};
        if (op == 6'h3B && i == 4'h0)
          e_g = m;
      end
      default: ;
    endcase
    e_pc = e_pc + (sk ? 12'h002 : 12'h001);
  endfunction

  task automatic exec(logic [15:0] w);
    insn_word = w;
    port_rd_data = 4'(rnd());
    clk_en = 1'b1;
    #1;
    chk("busy", 12'(w[15:10] == 6'h27), 12'(busy));
    if (w[15:10] == 6'h27) begin
      @(posedge clk);
      #1;
      chk("pc_held", e_pc, pc_q);
    end
    model(w, port_rd_data);
    @(posedge clk);
    #1;
    chk("pc", e_pc, pc_q);
    chk("borrow", 12'(e_b), 12'(borrow_q));
    chk("greg", 12'(e_g), 12'(greg_q));
    chk("rd_valid", 12'(e_rd.valid), 12'(port_rd_q.valid));
    chk("wr_valid", 12'(e_wr.valid), 12'(port_wr_q.valid));
    if (e_rd.valid)
      chk("port_rd", 12'(e_rd), 12'(port_rd_q));
    if (e_wr.valid)
      chk("port_wr", 12'(e_wr), 12'(port_wr_q));
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    // ram has no reset: fill all 256 nibbles first
    for (int a = 0; a < 64; a++) exec({6'h0F, 6'(a), 4'(rnd())});
    for (int a = 0; a < 16; a++) exec({6'h0F, 6'(a), 4'(a)});
    for (int g = 4; g < 16; g++) begin
      exec({6'h0F, 6'h10, 4'(g)});
      exec({6'h3B, 6'h10, 4'h0});
      exec({6'h0F, 6'h11, 4'(rnd())});
      for (int r = 0; r < 16; r++) exec({6'h26, 6'h11, 4'(r)});
    end
    $display("test fill done");
    exec({6'h0F, 6'h20, 4'h0});
    exec({6'h08, 6'h20, 4'h1});
    exec({6'h0C, 6'h20, 4'hF});
    exec({6'h0D, 6'h20, 4'h0});
    exec({6'h1C, 6'h20, 4'h0});
    exec({6'h31, 6'h20, 4'hF});
    for (int o = 0; o < 64; o++) exec({6'(o), 10'(rnd())});
    $display("test corners done");
    repeat (2000) exec(16'(rnd()));
    $display("test random done");
    clk_en = 1'b0;
    insn_word = 16'(rnd());
    @(posedge clk);
    #1;
    chk("pc_frozen", e_pc, pc_q);
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    e_pc = 12'h000;
    e_b = 1'b0;
    e_g = 4'h0;
    chk("pc_reset", e_pc, pc_q);
    chk("g_reset", 12'(e_g), 12'(greg_q));
    $display("test freeze and reset done");
    repeat (300) exec(16'(rnd()));
    for (int a = 0; a < 64; a++) exec({6'h3C, 6'(a), 4'h5});
    $display("test dump done");
    print_verdict();
  end
endmodule
`default_nettype wire
